// file: dcm_pkg.sv
/*
 * Shared constants and types for the dual coefficient multiply datapath.
 * Assumes a single clock domain and a 16-bit data memory word.
 */
package dcm_pkg;

	localparam int DCM_DATA_W = 16;  // Memory word width
	localparam int DCM_OP_W   = 17;  // Extended multiplier operand width
	localparam int DCM_PROD_W = 35;  // Product after fractional shift
	localparam int DCM_ACC_W  = 40;  // Destination accumulator width
	localparam int DCM_ADDR_W = 23;  // Word address width
	localparam int DCM_CNT_W  = 16;  // Repeat counter width
	localparam int DCM_RADR_W = 4;   // Register port address width

	// Register offsets on the plain register port
	localparam logic [DCM_RADR_W-1:0] DCM_REG_MODE   = 4'h0;
	localparam logic [DCM_RADR_W-1:0] DCM_REG_STATUS = 4'h1;
	localparam logic [DCM_RADR_W-1:0] DCM_REG_MASK   = 4'h2;

	// Mode register field positions
	localparam int DCM_MODE_FRAC = 0;  // fractional_mode
	localparam int DCM_MODE_PSAT = 1;  // product_saturate_mode
	localparam int DCM_MODE_WIDE = 2;  // wide_overflow_mode
	localparam int DCM_MODE_RDM  = 3;  // round_mode_select
	localparam int DCM_MODE_ASAT = 4;  // accum_saturate_enable
	localparam int DCM_MODE_W    = 5;

	// Status and mask field positions
	localparam int DCM_ST_OVF_LO = 0;  // Low destination overflow
	localparam int DCM_ST_OVF_HI = 1;  // High destination overflow
	localparam int DCM_ST_DONE   = 2;  // Instruction (and repeats) done
	localparam int DCM_ST_W      = 3;

	// Reset values
	localparam logic [DCM_MODE_W-1:0] DCM_MODE_RST = 5'h00;
	localparam logic [DCM_ST_W-1:0]   DCM_ST_RST   = 3'h0;
	localparam logic [DCM_ST_W-1:0]   DCM_MASK_RST = 3'h0;

	// Encoding sizes in bytes
	localparam logic [2:0] DCM_SIZE_SHORT = 3'h4;  // Single and long forms
	localparam logic [2:0] DCM_SIZE_DUAL  = 3'h5;  // Dual-operand form

	// Pointer steps
	localparam logic [DCM_ADDR_W-1:0] DCM_STEP_WORD = 23'h000001;
	localparam logic [DCM_ADDR_W-1:0] DCM_STEP_PAIR = 23'h000002;

	// Rounding and saturation constants
	localparam logic [DCM_ACC_W:0]   DCM_RND_HALF = 41'h00000008000;
	localparam logic [DCM_ACC_W-1:0] DCM_SAT_POS  = 40'h007fffffff;
	localparam logic [DCM_ACC_W-1:0] DCM_SAT_NEG  = 40'hff80000000;
	localparam logic [DCM_ACC_W-1:0] DCM_SATW_POS = 40'h7fffffffff;
	localparam logic [DCM_ACC_W-1:0] DCM_SATW_NEG = 40'h8000000000;
	localparam logic [DCM_OP_W-1:0]  DCM_OP_MIN   = 17'h18000;
	localparam logic [DCM_PROD_W-1:0] DCM_PSAT_VAL = 35'h00_7fffffff;

	typedef enum logic [1:0] {
		DCM_FORM_SINGLE = 2'b00,  // One data word shared by both multipliers
		DCM_FORM_LONG   = 2'b01,  // High/low halves of a long data word
		DCM_FORM_DUAL   = 2'b10   // Two independent data words
	} dcm_form_type;

	typedef enum logic [1:0] {
		DCM_PM_NONE = 2'b00,
		DCM_PM_INC  = 2'b01,
		DCM_PM_DEC  = 2'b10
	} dcm_post_type;

	typedef enum logic {
		DCM_ST_IDLE = 1'b0,
		DCM_ST_RUN  = 1'b1
	} dcm_state_type;

	typedef struct packed {
		dcm_state_type          st;        // Sequencer state
		logic [DCM_CNT_W-1:0]   remain;    // Repeats still to run
		dcm_form_type           form;      // Latched operand form
		dcm_post_type           xpm;       // X pointer post-modify
		dcm_post_type           ypm;       // Y pointer post-modify
		dcm_post_type           cpm;       // Coefficient pointer post-modify
		logic [DCM_ADDR_W-1:0]  xptr;      // X / data pointer
		logic [DCM_ADDR_W-1:0]  yptr;      // Y pointer
		logic [DCM_ADDR_W-1:0]  cptr;      // Coefficient pointer
		logic                   uns_data;  // Zero extend data operands
		logic                   uns_coef;  // Zero extend coefficient
		logic                   rnd;       // Round keyword
		logic                   kw40;      // Local wide overflow keyword
		logic [DCM_ACC_W-1:0]   acc_lo;    // Lower destination result
		logic [DCM_ACC_W-1:0]   acc_hi;    // Upper destination result
		logic                   ovf_lo;    // Lower overflow flag
		logic                   ovf_hi;    // Upper overflow flag
		logic                   wr;        // Results written this cycle
		logic [DCM_MODE_W-1:0]  mode;      // Mode register
		logic [DCM_ST_W-1:0]    status;    // Sticky status
		logic [DCM_ST_W-1:0]    mask;      // Interrupt mask
		logic [DCM_DATA_W-1:0]  rdata;     // Register read data
	} dcm_state_s_type;

endpackage : dcm_pkg

// file: dcm_mac_lane.sv
/*
 * One multiplier lane: extends, multiplies, shifts, rounds, checks overflow
 * and saturates. Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps

module dcm_mac_lane
	import dcm_pkg::*;
(
	input  logic [dcm_pkg::DCM_DATA_W-1:0] data_word,   // Data operand
	input  logic [dcm_pkg::DCM_DATA_W-1:0] coeff_word,  // Coefficient operand
	input  logic                           data_uns,    // Zero extend data
	input  logic                           coeff_uns,   // Zero extend coeff
	input  logic                           frac,        // Fractional shift
	input  logic                           psat,        // Product saturate
	input  logic                           wide,        // Effective wide mode
	input  logic                           rnd_en,      // Round keyword
	input  logic                           round_mode_select,         // Round method
	input  logic                           asat,        // Accum saturate
	output logic [dcm_pkg::DCM_ACC_W-1:0]  result,      // 40-bit result
	output logic                           overflow     // Destination overflow
);

	logic signed [DCM_OP_W-1:0]   op_a;     // Extended data
	logic signed [DCM_OP_W-1:0]   op_b;     // Extended coefficient
	logic signed [2*DCM_OP_W-1:0] prod;     // Raw product
	logic [DCM_PROD_W-1:0]        shifted;  // After fractional shift
	logic [DCM_ACC_W:0]           ext;      // Sign extended, one guard bit
	logic [DCM_ACC_W:0]           rounded;  // After rounding

	// Operand extension and multiply
	always_comb begin
		op_a = {(data_uns ? 1'b0 : data_word[DCM_DATA_W-1]), data_word};
		op_b = {(coeff_uns ? 1'b0 : coeff_word[DCM_DATA_W-1]), coeff_word};
		prod = (2*DCM_OP_W)'(op_a) * (2*DCM_OP_W)'(op_b);
		// Fractional mode doubles the product
		if (frac) begin
			shifted = {prod, 1'b0};
		end else begin
			shifted = {prod[2*DCM_OP_W-1], prod};
		end
		// Only -1 * -1 in fractional mode overflows a product
		if (psat && frac && op_a == DCM_OP_MIN && op_b == DCM_OP_MIN) begin
			shifted = DCM_PSAT_VAL;
		end
	end

	// Extension, rounding, overflow check and saturation
	always_comb begin
		ext     = {{(DCM_ACC_W+1-DCM_PROD_W){shifted[DCM_PROD_W-1]}}, shifted};
		rounded = ext;
		if (rnd_en) begin
			rounded = ext + DCM_RND_HALF;
			// Unbiased method: exact half rounds to even
			if (round_mode_select && ext[15:0] == 16'h8000) begin
				rounded[16] = 1'b0;
			end
			rounded[15:0] = 16'h0000;
		end
		// Narrow mode watches bits 40..31, wide mode the guard bit
		if (wide) begin
			overflow = rounded[DCM_ACC_W] ^ rounded[DCM_ACC_W-1];
		end else begin
			overflow = !(&rounded[DCM_ACC_W:31] || ~|rounded[DCM_ACC_W:31]);
		end
		result = rounded[DCM_ACC_W-1:0];
		if (overflow && asat) begin
			if (wide) begin
				result = rounded[DCM_ACC_W] ? DCM_SATW_NEG : DCM_SATW_POS;
			end else begin
				result = rounded[DCM_ACC_W] ? DCM_SAT_NEG : DCM_SAT_POS;
			end
		end
	end

endmodule : dcm_mac_lane

// file: dcm_datapath.sv
/*
 * Dual coefficient multiply datapath: two 17x17 multipliers sharing a
 * high/low coefficient pair, with repeat, pointer stepping and registers.
 * Assumes memory read buses answer combinationally within the issue cycle.
 */
// Our own choices: the strobed register port and the address map.
// Notes on behaviour
// - Both products finish in one cycle
// - Single form: one word feeds both multipliers
// - Upper coefficient at address to multiplier two
// - Lower coefficient at paired address, multiplier one
// - Long form: upper data half to multiplier two
// - Long form: lower data half, paired address
// - Unsigned keyword zero extends operand
// - Fractional mode shifts product left one
// - Product saturate mode governs multiply overflow
// - Result sign extended to 40 bits
// - Round keyword rounds by selected method
// - Overflow at chosen width sets flag
// - Saturate destination when enable says so
// - 40 keyword forces wide mode locally
// - Instruction may run under single repeat
// - High/low pointers step by two
// - Dual form is five bytes long
`timescale 1ns/1ps

module dcm_datapath
	import dcm_pkg::*;
(
	input  logic                           ref_clk,          // 10 MHz clock
	input  logic                           rstn,             // Sync reset, low
	// Instruction issue
	input  logic                           op_start,         // Issue pulse
	output logic                           op_ready,         // Can accept issue
	input  dcm_pkg::dcm_form_type          op_form,          // Operand form
	input  logic [dcm_pkg::DCM_CNT_W-1:0]  repeat_count,     // Extra iterations
	input  logic                           op_uns_data,      // Unsigned data
	input  logic                           op_uns_coeff,     // Unsigned coeff
	input  logic                           op_round,         // Round keyword
	input  logic                           op_wide40,        // 40 keyword
	input  dcm_pkg::dcm_post_type          x_post,           // X post-modify
	input  dcm_pkg::dcm_post_type          y_post,           // Y post-modify
	input  dcm_pkg::dcm_post_type          coeff_post,       // Coeff post-modify
	input  logic [dcm_pkg::DCM_ADDR_W-1:0] effective_addr,   // X path address
	input  logic [dcm_pkg::DCM_ADDR_W-1:0] y_addr_in,        // Y path address
	input  logic [dcm_pkg::DCM_ADDR_W-1:0] coeff_pointer,    // C path address
	output logic [2:0]                     op_size_bytes,    // Encoding length
	output logic                           op_pairable,      // Always low
	// Memory side
	output logic                           x_rd,             // X path read
	output logic [dcm_pkg::DCM_ADDR_W-1:0] x_addr,           // X address
	output logic                           x_pair_rd,        // Paired X read
	output logic [dcm_pkg::DCM_ADDR_W-1:0] x_pair_addr,      // Paired X address
	output logic                           y_rd,             // Y path read
	output logic [dcm_pkg::DCM_ADDR_W-1:0] y_addr,           // Y address
	output logic                           coeff_rd,         // Coeff read
	output logic [dcm_pkg::DCM_ADDR_W-1:0] coeff_address_bus, // Upper coeff addr
	output logic [dcm_pkg::DCM_ADDR_W-1:0] coeff_pair_addr,  // Lower coeff addr
	input  logic [dcm_pkg::DCM_DATA_W-1:0] operand_read_bus_d, // D read bus
	input  logic [dcm_pkg::DCM_DATA_W-1:0] operand_read_bus_c, // C read bus
	input  logic [dcm_pkg::DCM_DATA_W-1:0] coeff_high_bus,   // Upper coeff data
	input  logic [dcm_pkg::DCM_DATA_W-1:0] coeff_low_bus,    // Lower coeff data
	// Results
	output logic [dcm_pkg::DCM_ACC_W-1:0]  product_dest_low,  // Lower accum
	output logic [dcm_pkg::DCM_ACC_W-1:0]  product_dest_high, // Upper accum
	output logic                           low_dest_overflow_flag,  // Lower ovf
	output logic                           high_dest_overflow_flag, // Upper ovf
	output logic                           dest_write,       // Results updated
	output logic [dcm_pkg::DCM_ADDR_W-1:0] x_ptr_out,        // Updated X ptr
	output logic [dcm_pkg::DCM_ADDR_W-1:0] y_ptr_out,        // Updated Y ptr
	output logic [dcm_pkg::DCM_ADDR_W-1:0] coeff_ptr_out,    // Updated C ptr
	// Register port
	input  logic [dcm_pkg::DCM_RADR_W-1:0] reg_addr,         // Register offset
	input  logic [dcm_pkg::DCM_DATA_W-1:0] reg_wdata,        // Write data
	input  logic                           reg_wr,           // Write strobe
	input  logic                           reg_rd,           // Read strobe
	output logic [dcm_pkg::DCM_DATA_W-1:0] reg_rdata,        // Read data, +1 cycle
	output logic                           irq               // Level interrupt
);

	import dcm_pkg::*;

	dcm_state_s_type s_q;  // Registered state
	dcm_state_s_type s_d;  // Next state

	logic                  run;         // Executing an iteration
	logic [DCM_DATA_W-1:0] lo_data;     // Multiplier one data operand
	logic [DCM_DATA_W-1:0] hi_data;     // Multiplier two data operand
	logic [DCM_ACC_W-1:0]  lane_res[2]; // Lane results, 0 low 1 high
	logic [1:0]            lane_ovf;    // Lane overflows
	logic                  wide_eff;    // Effective wide overflow mode
	logic [DCM_ADDR_W-1:0] x_step;      // X pointer step for this form
	logic [DCM_ST_W-1:0]   st_clear;    // Write-one-to-clear mask

	// Pointer post-modify helper
	function automatic logic [DCM_ADDR_W-1:0] post_mod(
		input logic [DCM_ADDR_W-1:0] ptr,
		input dcm_post_type          pm,
		input logic [DCM_ADDR_W-1:0] step
	);
		logic [DCM_ADDR_W-1:0] r;
		r = ptr;
		case (pm)
			DCM_PM_INC: r = ptr + step;
			DCM_PM_DEC: r = ptr - step;
			default:    r = ptr;
		endcase
		return r;
	endfunction : post_mod

	// Address and operand routing for the current iteration
	always_comb begin
		run               = (s_q.st == DCM_ST_RUN);
		x_addr            = s_q.xptr;
		x_pair_addr       = s_q.xptr ^ DCM_STEP_WORD;
		y_addr            = s_q.yptr;
		coeff_address_bus = s_q.cptr;
		coeff_pair_addr   = s_q.cptr ^ DCM_STEP_WORD;
		coeff_rd          = run;
		x_rd              = run;
		x_pair_rd         = run && (s_q.form == DCM_FORM_LONG);
		y_rd              = run && (s_q.form == DCM_FORM_DUAL);
		// Coefficient halves only ever live in internal memory
		case (s_q.form)
			DCM_FORM_SINGLE: begin
				lo_data = operand_read_bus_d;
				hi_data = operand_read_bus_d;
				x_step  = DCM_STEP_WORD;
			end
			DCM_FORM_LONG: begin
				lo_data = operand_read_bus_d;
				hi_data = operand_read_bus_c;
				x_step  = DCM_STEP_PAIR;
			end
			DCM_FORM_DUAL: begin
				lo_data = operand_read_bus_d;
				hi_data = operand_read_bus_c;
				x_step  = DCM_STEP_WORD;
			end
			default: begin
				lo_data = operand_read_bus_d;
				hi_data = operand_read_bus_d;
				x_step  = DCM_STEP_WORD;
			end
		endcase
		wide_eff = s_q.mode[DCM_MODE_WIDE] | s_q.kw40;
	end

	// Two identical lanes: index 0 is multiplier one, index 1 multiplier two
	for (genvar g = 0; g < 2; g++) begin : g_lane
		dcm_mac_lane u_lane (
			.data_word  ((g == 0) ? lo_data : hi_data),
			.coeff_word ((g == 0) ? coeff_low_bus : coeff_high_bus),
			.data_uns   (s_q.uns_data),
			.coeff_uns  (s_q.uns_coef),
			.frac       (s_q.mode[DCM_MODE_FRAC]),
			.psat       (s_q.mode[DCM_MODE_PSAT]),
			.wide       (wide_eff),
			.rnd_en     (s_q.rnd),
			.round_mode_select        (s_q.mode[DCM_MODE_RDM]),
			.asat       (s_q.mode[DCM_MODE_ASAT]),
			.result     (lane_res[g]),
			.overflow   (lane_ovf[g])
		);
	end

	// Next-state logic: sequencer, results and registers
	always_comb begin
		s_d      = s_q;
		s_d.wr   = 1'b0;
		st_clear = '0;
		case (s_q.st)
			DCM_ST_IDLE: begin
				// Latch the instruction and its pointers
				if (op_start) begin
					s_d.st       = DCM_ST_RUN;
					s_d.remain   = repeat_count;
					s_d.form     = op_form;
					s_d.xpm      = x_post;
					s_d.ypm      = y_post;
					s_d.cpm      = coeff_post;
					s_d.xptr     = effective_addr;
					s_d.yptr     = y_addr_in;
					s_d.cptr     = coeff_pointer;
					s_d.uns_data = op_uns_data;
					s_d.uns_coef = op_uns_coeff;
					s_d.rnd      = op_round;
					s_d.kw40     = op_wide40;
				end
			end
			DCM_ST_RUN: begin
				// One iteration per cycle; both results land on the same edge
				s_d.acc_lo = lane_res[0];
				s_d.acc_hi = lane_res[1];
				s_d.ovf_lo = lane_ovf[0];
				s_d.ovf_hi = lane_ovf[1];
				s_d.wr     = 1'b1;
				s_d.xptr   = post_mod(s_q.xptr, s_q.xpm, x_step);
				s_d.yptr   = post_mod(s_q.yptr, s_q.ypm, DCM_STEP_WORD);
				s_d.cptr   = post_mod(s_q.cptr, s_q.cpm, DCM_STEP_PAIR);
				if (s_q.remain == '0) begin
					s_d.st = DCM_ST_IDLE;
				end else begin
					s_d.remain = s_q.remain - DCM_CNT_W'(1);
				end
			end
			default: begin
				s_d.st = DCM_ST_IDLE;
			end
		endcase
		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				DCM_REG_MODE:   s_d.mode = reg_wdata[DCM_MODE_W-1:0];
				DCM_REG_STATUS: st_clear = reg_wdata[DCM_ST_W-1:0];
				DCM_REG_MASK:   s_d.mask = reg_wdata[DCM_ST_W-1:0];
				default:        s_d.mode = s_q.mode;
			endcase
		end
		// Sticky status: a new event beats a clear in the same cycle
		s_d.status = s_q.status & ~st_clear;
		if (run) begin
			s_d.status[DCM_ST_OVF_LO] = s_d.status[DCM_ST_OVF_LO] | lane_ovf[0];
			s_d.status[DCM_ST_OVF_HI] = s_d.status[DCM_ST_OVF_HI] | lane_ovf[1];
			s_d.status[DCM_ST_DONE]   = s_d.status[DCM_ST_DONE] | (s_q.remain == '0);
		end
		// Register reads answer on the next cycle; holes read zero
		s_d.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				DCM_REG_MODE:   s_d.rdata = {{(DCM_DATA_W-DCM_MODE_W){1'b0}}, s_q.mode};
				DCM_REG_STATUS: s_d.rdata = {{(DCM_DATA_W-DCM_ST_W){1'b0}}, s_q.status};
				DCM_REG_MASK:   s_d.rdata = {{(DCM_DATA_W-DCM_ST_W){1'b0}}, s_q.mask};
				default:        s_d.rdata = '0;
			endcase
		end
	end

	// State register with synchronous reset
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s_q        <= '0;
			s_q.st     <= DCM_ST_IDLE;
			s_q.mode   <= DCM_MODE_RST;
			s_q.status <= DCM_ST_RST;
			s_q.mask   <= DCM_MASK_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Output assignments
	always_comb begin
		op_ready                = (s_q.st == DCM_ST_IDLE);
		op_size_bytes           = (op_form == DCM_FORM_DUAL) ? DCM_SIZE_DUAL
		                                                     : DCM_SIZE_SHORT;
		op_pairable             = 1'b0;
		product_dest_low        = s_q.acc_lo;
		product_dest_high       = s_q.acc_hi;
		low_dest_overflow_flag  = s_q.ovf_lo;
		high_dest_overflow_flag = s_q.ovf_hi;
		dest_write              = s_q.wr;
		x_ptr_out               = s_q.xptr;
		y_ptr_out               = s_q.yptr;
		coeff_ptr_out           = s_q.cptr;
		reg_rdata               = s_q.rdata;
		irq                     = |(s_q.status & s_q.mask);
	end

	// Checks on the datapath
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	AST_ONE_CYCLE: assert property (run && s_q.remain == '0 |=> dest_write && op_ready)
		else $error("last iteration did not finish in one cycle");
	AST_PAIR_LOW: assert property (run |-> coeff_pair_addr[0] != coeff_address_bus[0]
		&& coeff_pair_addr[DCM_ADDR_W-1:1] == coeff_address_bus[DCM_ADDR_W-1:1])
		else $error("lower coefficient address is not the paired address");
	AST_COEFF_STEP: assert property (run && s_q.cpm == DCM_PM_INC
		|=> coeff_ptr_out == $past(coeff_ptr_out) + DCM_STEP_PAIR)
		else $error("coefficient pointer did not step by two");
	AST_LONG_DEC: assert property (run && s_q.form == DCM_FORM_LONG && s_q.xpm == DCM_PM_DEC
		|=> x_ptr_out == $past(x_ptr_out) - DCM_STEP_PAIR)
		else $error("long data pointer did not step down by two");
	AST_SIGN_EXT: assert property (dest_write && !low_dest_overflow_flag
		|-> &product_dest_low[39:34] || ~|product_dest_low[39:34])
		else $error("lower result not sign extended");
	AST_ROUND_LOW: assert property (run && s_q.rnd ##1 !low_dest_overflow_flag
		|-> product_dest_low[15:0] == 16'h0000)
		else $error("rounded result has nonzero low half");
	AST_STICKY: assert property (dest_write && high_dest_overflow_flag
		|-> s_q.status[DCM_ST_OVF_HI])
		else $error("upper overflow not recorded");
	AST_OVF_SET: assert property (run && lane_ovf[1] |=> s_q.status[DCM_ST_OVF_HI])
		else $error("upper overflow status lost");
	AST_WIDE_KW: assert property (run && s_q.kw40 |-> wide_eff)
		else $error("40 keyword did not force wide mode");
	AST_KW_KEEP: assert property (op_ready && op_start |=> ##[1:2] s_q.mode[DCM_MODE_WIDE]
		== $past(s_q.mode[DCM_MODE_WIDE], 2) || $past(reg_wr, 2) || $past(reg_wr))
		else $error("stored wide mode changed by the keyword");
	AST_REPEAT: assert property (op_ready && op_start && repeat_count == 16'h0002
		|=> run [*3] ##1 op_ready)
		else $error("repeat ran the wrong number of iterations");
	AST_SIZE: assert property (op_form == DCM_FORM_DUAL |-> op_size_bytes == DCM_SIZE_DUAL)
		else $error("dual form size is not five bytes");

endmodule : dcm_datapath

// file: dcm_mem_model.sv
/* Memory model: each read returns the low word of its address.
   Assumes all coefficient space is internal and answers in-cycle. */
`timescale 1ns/1ps
module dcm_mem_model
	import dcm_pkg::*;
(
	input  logic                           x_rd,               // X read
	input  logic [dcm_pkg::DCM_ADDR_W-1:0] x_addr,             // X address
	input  logic                           x_pair_rd,          // Paired X read
	input  logic [dcm_pkg::DCM_ADDR_W-1:0] x_pair_addr,        // Paired X addr
	input  logic                           y_rd,               // Y read
	input  logic [dcm_pkg::DCM_ADDR_W-1:0] y_addr,             // Y address
	input  logic                           coeff_rd,           // Coeff read
	input  logic [dcm_pkg::DCM_ADDR_W-1:0] coeff_address_bus,  // Upper coeff
	input  logic [dcm_pkg::DCM_ADDR_W-1:0] coeff_pair_addr,    // Lower coeff
	output logic [dcm_pkg::DCM_DATA_W-1:0] operand_read_bus_d, // D bus
	output logic [dcm_pkg::DCM_DATA_W-1:0] operand_read_bus_c, // C bus
	output logic [dcm_pkg::DCM_DATA_W-1:0] coeff_high_bus,     // Upper data
	output logic [dcm_pkg::DCM_DATA_W-1:0] coeff_low_bus       // Lower data
);
	logic [DCM_ADDR_W-1:0] da, ca;  // Address behind each data bus
	assign da = x_pair_rd ? x_pair_addr : x_addr;
	assign ca = y_rd ? y_addr : x_addr;
	// Idle buses show the inverted word, so stale data never matches
	assign operand_read_bus_d = x_rd ? da[15:0] : ~da[15:0];
	assign operand_read_bus_c = x_rd ? ca[15:0] : ~ca[15:0];
	// Coefficients only ever come from internal space
	assign coeff_high_bus = coeff_rd ? coeff_address_bus[15:0] : ~coeff_address_bus[15:0];
	assign coeff_low_bus  = coeff_rd ? coeff_pair_addr[15:0] : ~coeff_pair_addr[15:0];
endmodule : dcm_mem_model

// file: tb_dual_coeff_multiply_datapath.sv
/* Register and instruction bench for the dual multiply datapath.
   Assumes the address-as-data memory model on the far side. */
`timescale 1ns/1ps
module tb_dual_coeff_multiply_datapath;
	import dcm_pkg::*;
	logic ref_clk, rstn, op_start, op_ready, op_uns_data, op_uns_coeff, op_round, op_wide40;
	logic op_pairable, x_rd, x_pair_rd, y_rd, coeff_rd, dest_write, reg_wr, reg_rd, irq;
	logic low_dest_overflow_flag, high_dest_overflow_flag;
	dcm_form_type op_form;
	dcm_post_type x_post, y_post, coeff_post;
	logic [DCM_CNT_W-1:0] repeat_count;
	logic [DCM_ADDR_W-1:0] effective_addr, y_addr_in, coeff_pointer, x_addr, x_pair_addr, y_addr;
	logic [DCM_ADDR_W-1:0] coeff_address_bus, coeff_pair_addr, x_ptr_out, y_ptr_out, coeff_ptr_out;
	logic [2:0] op_size_bytes;
	logic [15:0] operand_read_bus_d, operand_read_bus_c, coeff_high_bus, coeff_low_bus;
	logic [15:0] reg_wdata, reg_rdata, rv;
	logic [3:0] reg_addr;
	logic [39:0] product_dest_low, product_dest_high;
	int n_fail, check_count, n;
	dcm_datapath i_dut(.*);
	dcm_mem_model i_mem(.*);
	// Free-running 100 ns clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic complete_run;
		if (n_fail == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic chk(logic [39:0] got, logic [39:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Expected product, extended per operand signedness
	function automatic logic [39:0] mul(logic [15:0] a, logic [15:0] b, logic u);
		logic [39:0] sa, sb;
		sa = u ? {24'h0, a} : {{24{a[15]}}, a};
		sb = u ? {24'h0, b} : {{24{b[15]}}, b};
		return sa * sb;
	endfunction : mul
	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task automatic rd(logic [3:0] a, logic [15:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk(40'(reg_rdata), 40'(e));
	endtask : rd
	// Issue one instruction and wait for its first result
	task automatic run(dcm_form_type f, logic [22:0] ea, logic [22:0] ya, logic [22:0] ca,
		logic u, logic [1:0] kw, logic [15:0] rc);
		int k;
		@(posedge ref_clk);
		op_form <= f;
		effective_addr <= ea;
		y_addr_in <= ya;
		coeff_pointer <= ca;
		{op_uns_data, op_uns_coeff} <= {u, u};
		{op_wide40, op_round} <= kw;
		repeat_count <= rc;
		op_start <= 1'b1;
		@(posedge ref_clk);
		op_start <= 1'b0;
		for (k = 0; k < 20 && dest_write !== 1'b1; k++) @(negedge ref_clk);
		if (k == 20) begin
			n_fail++;
			complete_run();
		end
	endtask : run
	initial begin
		{rstn, op_start, op_uns_data, op_uns_coeff, op_round, op_wide40, reg_wr, reg_rd} = '0;
		{effective_addr, y_addr_in, coeff_pointer, repeat_count, reg_addr, reg_wdata} = '0;
		op_form = DCM_FORM_SINGLE;
		x_post = DCM_PM_DEC;
		y_post = DCM_PM_INC;
		coeff_post = DCM_PM_INC;
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		for (int a = 0; a < 3; a++) rd(4'(a), 16'h0000);
		run(DCM_FORM_SINGLE, 23'hfff0, 0, 23'h20, 0, 0, 0);
		chk(product_dest_high, mul(16'hfff0, 16'h0020, 0));
		chk(product_dest_low, mul(16'hfff0, 16'h0021, 0));
		chk(40'(x_ptr_out), 40'h00ffef);
		chk(40'(coeff_ptr_out), 40'h22);
		chk(40'({op_size_bytes, op_pairable}), 40'h8);
		run(DCM_FORM_LONG, 23'h31, 0, 23'h41, 0, 0, 0);
		chk(product_dest_high, mul(16'h0031, 16'h0041, 0));
		chk(product_dest_low, mul(16'h0030, 16'h0040, 0));
		chk(40'(x_ptr_out), 40'h2f);
		run(DCM_FORM_DUAL, 23'h5, 23'h7, 23'h8, 0, 0, 0);
		chk(product_dest_low, mul(16'h0005, 16'h0009, 0));
		chk(product_dest_high, mul(16'h0007, 16'h0008, 0));
		chk(40'(op_size_bytes), 40'h5);
		chk(40'(y_ptr_out), 40'h8);
		run(DCM_FORM_SINGLE, 23'hffff, 0, 23'h2, 1, 0, 0);
		chk(product_dest_low, mul(16'hffff, 16'h0003, 1));
		run(DCM_FORM_SINGLE, 23'h100, 0, 23'h80, 0, 2'b01, 0);
		chk(product_dest_low, 40'h10000);
		chk(product_dest_high, 40'h10000);
		wr(DCM_REG_MODE, 16'h0011);
		run(DCM_FORM_SINGLE, 23'h8000, 0, 23'h8000, 0, 0, 0);
		chk(product_dest_high, DCM_SAT_POS);
		chk(product_dest_low, mul(16'h8000, 16'h8001, 0) << 1);
		chk(40'({high_dest_overflow_flag, low_dest_overflow_flag}), 40'h2);
		rd(DCM_REG_STATUS, 16'h0006);
		chk(40'(irq), 40'h0);
		wr(DCM_REG_MASK, 16'h0002);
		@(negedge ref_clk) chk(40'(irq), 40'h1);
		wr(DCM_REG_STATUS, 16'h0002);
		@(negedge ref_clk) chk(40'(irq), 40'h0);
		rd(DCM_REG_STATUS, 16'h0004);
		rd(4'hf, 16'h0000);
		run(DCM_FORM_SINGLE, 23'h8000, 0, 23'h8000, 0, 2'b10, 0);
		chk(product_dest_high, 40'h0080000000);
		rd(DCM_REG_MODE, 16'h0011);
		wr(DCM_REG_MODE, 16'h0003);
		run(DCM_FORM_SINGLE, 23'h8000, 0, 23'h8000, 0, 0, 0);
		chk(product_dest_high, 40'h007fffffff);
		chk(40'({high_dest_overflow_flag, low_dest_overflow_flag}), 40'h0);
		wr(DCM_REG_MODE, 16'h0008);
		run(DCM_FORM_SINGLE, 23'h100, 0, 23'h80, 0, 2'b01, 0);
		chk(product_dest_high, 40'h0);
		chk(product_dest_low, 40'h10000);
		run(DCM_FORM_SINGLE, 23'h10, 0, 23'h20, 0, 0, 2);
		n = 1;
		repeat (4) @(negedge ref_clk) n += int'(dest_write === 1'b1);
		chk(40'(n), 40'h3);
		chk(40'(coeff_ptr_out), 40'h26);
		chk(40'(op_ready), 40'h1);
		complete_run();
	end
endmodule : tb_dual_coeff_multiply_datapath
